// File: src/flash_status_pkg.sv
// Constants shared by the flash status and protection logic.
// ==========================================================
// Contract
// - Lock set: sector protect commands ignored.
// - Lock set: no global protect or unprotect.
// - Lock clear: protect requests processed normally.
// - Lock clears on power-up and device reset.
// - Protect pin asserted: lock may only rise; the enabled reset command still clears it.
// - Status one write changes only bit seven.
// - Program mode flag shown, byte mode after reset.
// - Error flag set when a byte failed.
// - Aborted operations leave error flag unset.
// - Read-only bit mirrors protect pin.
// - Summary bits encode none, some, all.
// - Latch clear rejects all write commands.
// - Latch clears after writes complete or stop.
// - Incomplete opcode keeps the latch set.
// - Busy bit in both bytes, always readable.
// - Reset command needs the reset enable bit.
// - Reset enable kept through reset command.
// - Byte two write changes bit four only.
// - Status interrupt drives busy on output continuously.
// - Chip select high ends interrupt, output off.
// - Illegal lock clear ignored, latch cleared.
package flash_status_pkg;
  // Opcodes. Read byte two and reset opcodes are local picks.
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_RDSR1  = 8'h05;
  localparam logic [7:0] OP_RDSR2  = 8'h35;
  localparam logic [7:0] OP_WRSR1  = 8'h01;
  localparam logic [7:0] OP_WRSR2  = 8'h31;
  localparam logic [7:0] OP_ASI    = 8'h25;
  localparam logic [7:0] OP_PROT   = 8'h36;
  localparam logic [7:0] OP_UNPROT = 8'h39;
  localparam logic [7:0] OP_RESET  = 8'hf0;
  // Field positions of the two status bytes.
  localparam int LOCK_POS  = 7;
  localparam int PMODE_POS = 6;
  localparam int EPE_POS   = 5;
  localparam int WPP_POS   = 4;
  localparam int SWP_LO    = 2;
  localparam int WEL_POS   = 1;
  localparam int RDY_POS   = 0;
  localparam int RESET_ENABLE_BIT_POS  = 4;
  // Reset values.
  localparam logic LOCK_RST = 1'b0;
  localparam logic WEL_RST  = 1'b0;
  localparam logic RESET_ENABLE_BIT_RST = 1'b0;
  localparam logic EPE_RST  = 1'b0;
  // Software protection summary codes.
  localparam logic [1:0] SWP_NONE = 2'h0;
  localparam logic [1:0] SWP_SOME = 2'h1;
  localparam logic [1:0] SWP_ALL  = 2'h3;
  // Global protect field values in the byte one data.
  localparam logic [3:0] GP_ALL  = 4'hf;
  localparam logic [3:0] GP_NONE = 4'h0;
  // Serial engine states, one-hot.
  typedef enum logic [4:0] {
    ST_CMD   = 5'h01,
    ST_WDATA = 5'h02,
    ST_READ  = 5'h04,
    ST_ASI   = 5'h08,
    ST_SKIP  = 5'h10
  } ser_state_type;
endpackage

// File: src/flash_status_regs.sv
// Status bytes, protection lock and serial command front end.
`timescale 1ns/100ps
module flash_status_regs
  import flash_status_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Serial pins.
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic wp_n,
  output logic      so,
  output logic      so_oe,
  // Array engine side.
  input  wire logic busy,
  input  wire logic seq_mode,
  input  wire logic op_done,
  input  wire logic op_fail,
  input  wire logic op_aborted,
  input  wire logic wel_clr_evt,
  input  wire logic any_protected,
  input  wire logic all_protected,
  output logic      write_enable,
  output logic      protect_req,
  output logic      unprotect_req,
  output logic      global_prot_req,
  output logic      global_unprot_req,
  output logic      dev_reset
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [3:0] s1_r;     // First stage, read only by s2_r.
  logic [3:0] s2_r;     // Second stage: cs_n, sck, si, wp_n.
  logic       sck_d_r;  // Delayed sck for edge detection.
  logic       cs_d_r;   // Delayed chip select.

  // Every pin passes two flops before any logic sees it.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r    <= 4'hf;
      s2_r    <= 4'hf;
      sck_d_r <= 1'b1;
      cs_d_r  <= 1'b1;
    end else begin
      s1_r    <= {cs_n, sck, si, wp_n};
      s2_r    <= s1_r;
      sck_d_r <= s2_r[2];
      cs_d_r  <= s2_r[3];
    end
  end

  logic cs_on;     // Chip select asserted.
  logic cs_end;    // Chip select just released.
  logic sck_rise;  // Sampling edge.
  logic sck_fall;  // Shift-out edge.
  logic wp_on;     // Protect pin asserted.
  assign cs_on    = ~s2_r[3];
  assign cs_end   = s2_r[3] & ~cs_d_r;
  assign sck_rise = cs_on & s2_r[2] & ~sck_d_r;
  assign sck_fall = cs_on & ~s2_r[2] & sck_d_r;
  assign wp_on    = ~s2_r[0];

  // ==========================================================
  // Status bits
  // ==========================================================
  logic lock_r;  // Protection lock bit.
  logic wel_r;   // Write enable latch.
  logic epe_r;   // Erase/program error flag.
  logic reset_enable_bit_r;  // Reset enable bit.
  logic [1:0] software_protection_summary;

  // Summary code; "all" wins so the three codes stay distinct.
  always_comb begin
    if (all_protected) begin
      software_protection_summary = SWP_ALL;
    end else if (any_protected) begin
      software_protection_summary = SWP_SOME;
    end else begin
      software_protection_summary = SWP_NONE;
    end
  end

  // Builds a fresh byte at each call so readers see live busy.
  function automatic logic [7:0] stat_byte(input logic two);
    logic [7:0] b;
    b = 8'h00;
    if (two) begin
      b[RESET_ENABLE_BIT_POS] = reset_enable_bit_r;  // Others read zero except busy.
    end else begin
      b[LOCK_POS]          = lock_r;
      b[PMODE_POS]         = seq_mode;
      b[EPE_POS]           = epe_r;
      b[WPP_POS]           = wp_on;
      b[SWP_LO+1:SWP_LO]   = software_protection_summary;
      b[WEL_POS]           = wel_r;
    end
    b[RDY_POS] = busy;
    return b;
  endfunction

  // ==========================================================
  // Serial receive
  // ==========================================================
  ser_state_type st_r;
  logic [7:0] sh_r;     // Incoming bits.
  logic [2:0] bit_r;    // Bit within byte.
  logic [1:0] bytes_r;  // Whole bytes, saturating at three.
  logic [7:0] op_r;     // Latched opcode.
  logic [7:0] dat_r;    // First data byte.
  logic       dok_r;    // First data byte complete.
  logic [7:0] rx;       // Byte including the current bit.
  logic       byte_dn;  // Eighth bit taken.
  assign rx      = {sh_r[6:0], s2_r[1]};
  assign byte_dn = sck_rise & (bit_r == 3'h7);

  // Bit and byte counting; cleared while chip select is high.
  always_ff @(posedge clk) begin
    if (rst || !cs_on) begin
      sh_r    <= 8'h00;
      bit_r   <= 3'h0;
      bytes_r <= 2'h0;
    end else if (sck_rise) begin
      sh_r  <= rx;
      bit_r <= bit_r + 3'h1;
      if (bit_r == 3'h7 && bytes_r != 2'h3) begin
        bytes_r <= bytes_r + 2'h1;
      end
    end
  end

  // Command decode at the end of the opcode byte.
  always_ff @(posedge clk) begin
    if (rst || !cs_on) begin
      st_r  <= ST_CMD;
      op_r  <= 8'h00;
      dat_r <= 8'h00;
      dok_r <= 1'b0;
    end else if (byte_dn) begin
      unique case (st_r)
        ST_CMD: begin
          op_r <= rx;
          if (rx == OP_RDSR1 || rx == OP_RDSR2) begin
            st_r <= ST_READ;
          end else if (rx == OP_ASI) begin
            st_r <= ST_ASI;  // Mode 3 dummy bit is simply ignored.
          end else if (rx == OP_WRSR1 || rx == OP_WRSR2) begin
            st_r <= ST_WDATA;
          end else begin
            st_r <= ST_SKIP;
          end
        end
        ST_WDATA: begin
          dat_r <= rx;  // Later bytes are ignored.
          dok_r <= 1'b1;
          st_r  <= ST_SKIP;
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end

  // ==========================================================
  // Command execution at chip select release
  // ==========================================================
  logic got_op;   // Full opcode was received.
  logic do_w1;    // Byte one write executes.
  logic bad_clr;  // Lock clear under an asserted pin.
  logic act;      // Any full command with latch set, not busy.
  assign got_op  = cs_end & (bytes_r != 2'h0);
  assign act     = got_op & wel_r & ~busy;
  assign bad_clr = lock_r & ~dat_r[LOCK_POS] & wp_on;
  assign do_w1   = act & (op_r == OP_WRSR1) & dok_r & ~bad_clr;

  // Lock bit: only bit seven of the data is ever stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_r <= LOCK_RST;
    end else if (got_op && op_r == OP_RESET && reset_enable_bit_r) begin
      lock_r <= LOCK_RST;
    end else if (do_w1) begin
      lock_r <= dat_r[LOCK_POS];
    end
  end

  // Reset enable survives the reset command itself.
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_enable_bit_r <= RESET_ENABLE_BIT_RST;
    end else if (act && op_r == OP_WRSR2 && dok_r && bit_r == 3'h0) begin
      reset_enable_bit_r <= dat_r[RESET_ENABLE_BIT_POS];
    end
  end

  // Write enable latch; a set in the same cycle as a clear wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      wel_r <= WEL_RST;
    end else if (got_op && op_r == OP_WREN) begin
      wel_r <= 1'b1;
    end else if (got_op && op_r == OP_RESET && reset_enable_bit_r) begin
      wel_r <= WEL_RST;
    end else if (wel_clr_evt) begin
      wel_r <= 1'b0;
    end else if (got_op && (op_r == OP_WRDI || op_r == OP_WRSR1 ||
                 op_r == OP_WRSR2 || op_r == OP_PROT || op_r == OP_UNPROT)) begin
      wel_r <= 1'b0;
    end
  end

  // Error flag refreshed by each finished operation.
  always_ff @(posedge clk) begin
    if (rst) begin
      epe_r <= EPE_RST;
    end else if (op_done) begin
      epe_r <= op_fail & ~op_aborted;
    end
  end

  // Requests to the sector protection logic, plus the device reset, one pulse each.
  always_ff @(posedge clk) begin
    if (rst) begin
      protect_req       <= 1'b0;
      unprotect_req     <= 1'b0;
      global_prot_req   <= 1'b0;
      global_unprot_req <= 1'b0;
      dev_reset         <= 1'b0;
    end else begin
      protect_req       <= act & ~lock_r & (op_r == OP_PROT);
      unprotect_req     <= act & ~lock_r & (op_r == OP_UNPROT);
      // Prior lock state decides the global action.
      global_prot_req   <= do_w1 & ~lock_r & (dat_r[5:2] == GP_ALL);
      global_unprot_req <= do_w1 & ~lock_r & (dat_r[5:2] == GP_NONE);
      dev_reset         <= got_op & (op_r == OP_RESET) & reset_enable_bit_r;
    end
  end
  assign write_enable = wel_r;

  // ==========================================================
  // Serial output
  // ==========================================================
  logic [7:0] osh_r;  // Outgoing bits.
  logic [2:0] obit_r; // Output bit within byte.
  logic       so_r;
  logic       oe_r;
  logic [7:0] fresh;  // Status byte for the command in progress.

  // Built every cycle, so the byte loaded at a byte boundary carries live busy.
  always_comb begin
    fresh = stat_byte(op_r == OP_RDSR2);
  end

  // Read shifts a fresh status byte every eight falls, so a host
  // polling busy always sees live data; the interrupt mode
  // instead follows busy on every clock.
  always_ff @(posedge clk) begin
    if (rst || !cs_on || !(st_r == ST_READ || st_r == ST_ASI)) begin
      osh_r  <= 8'h00;
      obit_r <= 3'h0;
      so_r   <= 1'b0;
    end else if (st_r == ST_ASI) begin
      so_r <= busy;
    end else if (sck_fall) begin
      obit_r <= obit_r + 3'h1;
      if (obit_r == 3'h0) begin
        osh_r <= {fresh[6:0], 1'b0};
        so_r  <= fresh[7];
      end else begin
        osh_r <= {osh_r[6:0], 1'b0};
        so_r  <= osh_r[7];
      end
    end
  end

  // Driver released one clock after chip select is seen high.
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= cs_on & (st_r == ST_READ || st_r == ST_ASI);
    end
  end
  assign so    = so_r;
  assign so_oe = oe_r;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  lock_reset_a: assert property (dev_reset |-> !lock_r)
    else $error("lock not cleared by device reset");
  lock_pin_a: assert property (lock_r && wp_on && !dev_reset |=> lock_r || dev_reset)
    else $error("lock cleared while protect pin asserted");
  prot_lock_a: assert property (lock_r |=> !protect_req && !unprotect_req)
    else $error("sector request while locked");
  glob_lock_a: assert property (lock_r |=> !global_prot_req && !global_unprot_req)
    else $error("global request while locked");
  lock_wel_a: assert property ($rose(lock_r) |-> $past(wel_r))
    else $error("lock changed without write enable");
  reset_enable_bit_keep_a: assert property (dev_reset |-> $stable(reset_enable_bit_r))
    else $error("reset enable changed by reset");
  reset_gate_a: assert property (dev_reset |-> $past(reset_enable_bit_r))
    else $error("reset honoured while disabled");
  asi_follow_a: assert property (st_r == ST_ASI && cs_on ##1 st_r == ST_ASI
    |-> so_r == $past(busy))
    else $error("status interrupt output not following busy");
  cs_off_a: assert property (!cs_on |=> !so_oe)
    else $error("output driven after chip select release");
  epe_upd_a: assert property (op_done |=> epe_r == $past(op_fail && !op_aborted))
    else $error("error flag not refreshed");

  wrsr_cov_c: cover property (do_w1);
  asi_cov_c: cover property (st_r == ST_ASI && $fell(busy));
  rst_cov_c: cover property (dev_reset);
  gprot_cov_c: cover property (global_prot_req);

endmodule

// File: bench/spi_host_model.sv
// Host serial controller model driving the flash status block.
`timescale 1ns/100ps
module spi_host_model (
  // Clock.
  input  wire logic clk,
  // Serial pins.
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  // A released line floats. The model shows the inverse of so, which the
  // device holds at zero while released, so a released line reads as one.
  logic so_seen;
  assign so_seen = so_oe ? so : ~so;

  // ==========================================================
  // Idle state: deselected, clock parked low between frames.
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Waits n clocks, then steps just past the edge.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One mode 0 frame, MSB first; reply bits are taken late in the high
  // phase because the device shifts its output on the falling edge.
  task automatic frame(input logic [15:0] d, input int n, input bit keep,
                       output logic [7:0] rd);
    rd   = 8'h00;
    cs_n = 1'b0;
    wt(2);
    for (int i = 0; i < n; i++) begin
      si = d[15-i];
      wt(4);
      sck = 1'b1;
      wt(4);
      if (i >= 8) begin
        rd = {rd[6:0], so_seen};
      end
      sck = 1'b0;
    end
    // The data line no longer carries the last bit once the frame ends.
    si = ~si;
    wt(2);
    if (!keep) begin
      cs_n = 1'b1;
      wt(8);
    end
  endtask

  // Ends a frame left open, such as the status interrupt.
  task automatic stop();
    cs_n = 1'b1;
    wt(8);
  endtask
endmodule

// File: bench/tb_flash_status_regs.sv
// Self-checking bench for the flash status and protection block.
`timescale 1ns/100ps
module tb_flash_status_regs import flash_status_pkg::*; ;
  // ==========================================================
  // Signals.
  logic clk, rst, cs_n, sck, si, wp_n, so, so_oe, busy, seq_mode;
  logic op_done, op_fail, op_aborted, wel_clr_evt;
  logic any_protected, all_protected, write_enable;
  logic protect_req, unprotect_req, global_prot_req, global_unprot_req;
  logic dev_reset;
  logic [7:0] r;
  logic [7:0] c_p, c_u, c_gp, c_gu, c_rs; // Pulse tallies.
  int n_mismatch, samples_checked;

  flash_status_regs u_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe(so_oe), .busy(busy), .seq_mode(seq_mode),
    .op_done(op_done), .op_fail(op_fail), .op_aborted(op_aborted),
    .wel_clr_evt(wel_clr_evt), .any_protected(any_protected),
    .all_protected(all_protected), .write_enable(write_enable),
    .protect_req(protect_req), .unprotect_req(unprotect_req),
    .global_prot_req(global_prot_req), .global_unprot_req(global_unprot_req),
    .dev_reset(dev_reset));
  spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
    .so_oe(so_oe));

  // Clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts each one-cycle request pulse so missing or extra ones show.
  always @(posedge clk) begin
    c_p  <= c_p + protect_req;
    c_u  <= c_u + unprotect_req;
    c_gp <= c_gp + global_prot_req;
    c_gu <= c_gu + global_unprot_req;
    c_rs <= c_rs + dev_reset;
  end

  // ==========================================================
  // Helpers.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host.frame({op, 8'h00}, 8, 1'b0, r);
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    host.frame({op, d}, 16, 1'b0, r);
  endtask
  task automatic c1(input logic [7:0] e);
    host.frame({OP_RDSR1, 8'h00}, 16, 1'b0, r);
    chk(r, e);
  endtask
  task automatic c2(input logic [7:0] e);
    host.frame({OP_RDSR2, 8'h00}, 16, 1'b0, r);
    chk(r, e);
  endtask
  // Engine completion pulse with its qualifiers.
  task automatic ev(input logic f, input logic a);
    op_fail    = f;
    op_aborted = a;
    op_done    = 1'b1;
    tick(1);
    op_done = 1'b0;
    tick(4);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_reset();
    c1(8'h00);
    c2(8'h00);
    seq_mode = 1'b1;
    c1(8'h40);
    seq_mode = 1'b0;
  endtask
  // Lock set with the pin asserted, plus global protect while unlocked.
  task automatic t_lock();
    wp_n = 1'b0;
    cmd(OP_WREN);
    c1(8'h12);
    wr(OP_WRSR1, 8'hff);
    c1(8'h90);
    chk(c_gp, 8'h01);
  endtask
  task automatic t_locked();
    cmd(OP_WREN);
    cmd(OP_PROT);
    cmd(OP_WREN);
    cmd(OP_UNPROT);
    c1(8'h90);
    chk({c_p[3:0], c_u[3:0]}, 8'h00);
    cmd(OP_WREN);
    wr(OP_WRSR1, 8'hbc);
    chk(c_gp, 8'h01);
  endtask
  task automatic t_wp();
    cmd(OP_WREN);
    wr(OP_WRSR1, 8'h00);
    c1(8'h90);
    wp_n = 1'b1;
    cmd(OP_WREN);
    wr(OP_WRSR1, 8'h00);
    c1(8'h00);
    chk(c_gu, 8'h00);
  endtask
  task automatic t_prot();
    cmd(OP_PROT);
    chk(c_p, 8'h00);
    cmd(OP_WREN);
    cmd(OP_PROT);
    cmd(OP_WREN);
    cmd(OP_UNPROT);
    chk({c_p[3:0], c_u[3:0]}, 8'h11);
    c1(8'h00);
    cmd(OP_WREN);
    wr(OP_WRSR1, 8'h00);
    chk(c_gu, 8'h01);
  endtask
  // A torn opcode keeps the latch; engine events and disable clear it.
  task automatic t_wel();
    cmd(OP_WREN);
    host.frame({OP_WRSR1, 8'h00}, 4, 1'b0, r);
    chk({7'h00, write_enable}, 8'h01);
    c1(8'h02);
    wel_clr_evt = 1'b1;
    tick(1);
    wel_clr_evt = 1'b0;
    c1(8'h00);
    cmd(OP_WREN);
    cmd(OP_WRDI);
    c1(8'h00);
  endtask
  task automatic t_epe();
    ev(1'b1, 1'b0);
    c1(8'h20);
    ev(1'b0, 1'b0);
    c1(8'h00);
    ev(1'b1, 1'b1);
    c1(8'h00);
  endtask
  task automatic t_swp();
    any_protected = 1'b1;
    c1(8'h04);
    all_protected = 1'b1;
    busy = 1'b1;
    c1(8'h0d);
    c2(8'h01);
    {any_protected, all_protected, busy} = 3'h0;
  endtask
  // Host polls byte two until busy falls, with a bounded number of reads.
  task automatic t_poll();
    int k;
    k = 0;
    busy = 1'b1;
    r = 8'h01;
    while (r[0] && k < 8) begin
      host.frame({OP_RDSR2, 8'h00}, 16, 1'b0, r);
      k++;
      if (k == 2) begin
        busy = 1'b0;
      end
    end
    chk(k[7:0], 8'h03);
    chk(r, 8'h00);
  endtask
  // Power-up reset in mid-run clears lock, latch and reset enable.
  task automatic t_por();
    cmd(OP_WREN);
    wr(OP_WRSR1, 8'h80);
    cmd(OP_WREN);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(4);
    chk({7'h00, write_enable}, 8'h00);
    c1(8'h00);
    c2(8'h00);
  endtask
  task automatic t_reset_enable_bit();
    cmd(OP_RESET);
    chk(c_rs, 8'h00);
    cmd(OP_WREN);
    wr(OP_WRSR2, 8'hff);
    c2(8'h10);
    cmd(OP_WREN);
    wr(OP_WRSR1, 8'h80);
    cmd(OP_RESET);
    chk(c_rs, 8'h01);
    c1(8'h00);
    c2(8'h10);
  endtask
  // Status interrupt follows busy with no serial clock, ends on deselect.
  task automatic t_asi();
    busy = 1'b1;
    host.frame({OP_ASI, 8'h00}, 8, 1'b1, r);
    tick(6);
    chk({6'h00, so_oe, so}, 8'h03);
    busy = 1'b0;
    tick(6);
    chk({6'h00, so_oe, so}, 8'h02);
    host.stop();
    chk({7'h00, so_oe}, 8'h00);
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    {rst, wp_n} = 2'b11;
    {busy, seq_mode, op_done, op_fail, op_aborted} = 5'h00;
    {wel_clr_evt, any_protected, all_protected} = 3'h0;
    {c_p, c_u, c_gp, c_gu, c_rs} = 40'h0;
    n_mismatch = 0;
    samples_checked = 0;
    tick(2);
    rst = 1'b0;
    tick(4);
    t_reset();
    t_lock();
    t_locked();
    t_wp();
    t_prot();
    t_wel();
    t_epe();
    t_swp();
    t_poll();
    t_reset_enable_bit();
    t_por();
    t_asi();
    end_sim();
  end

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule
